// ==== dv/afe_serial_frame_port_test.sv ====
// Self-checking bench of the serial frame port against a processor model.
// Assumes the checker binds itself; the master clock is made here.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module afe_serial_frame_port_test;
    import afesp_pkg::*;
    logic clk = 1'b0;
    logic rst_i = 1'b1;
    logic mclk_i;
    logic [2:0] osr_n_i = 3'h3;
    logic hw_req = 1'b0;
    logic rdy = 1'b0;
    logic [15:0] adc = 16'h1234, rb = 16'h0f0f, tx = 16'h0000, got, rx_w;
    logic [15:0] lf = 16'h6cda;
    logic [3:0] mdiv = 4'h0;
    logic din, dout, sclk, fs, rx_c, rx_v, adc_rdy;
    int error_cnt = 0, compares = 0, got_cnt, cyc = 0, mode = 0, t_fall;
    afesp_word_t cur, q[$];
    initial begin
        forever #20 clk = ~clk;
    end
    // The master clock runs at a quarter of the system clock.
    always @(negedge clk) begin
        mdiv <= mdiv + 4'h1;
        cyc <= cyc + 1;
    end
    assign mclk_i = mdiv[1];
    always @(negedge fs) t_fall = cyc;
    afesp_port dut (.clk_i(clk), .rst_i, .mclk_i, .osr_n_i,
        .hw_ctrl_req_i(hw_req), .adc_word_i(adc), .adc_valid_i(1'b1),
        .readback_i(rb), .serial_in_i(din), .serial_out_o(dout),
        .shift_clk_o(sclk), .frame_sync_out_o(fs), .rx_word_o(rx_w),
        .rx_ctrl_o(rx_c), .rx_valid_o(rx_v), .rx_ready_i(rdy),
        .adc_ready_o(adc_rdy));
    afesp_dsp_model dsp (.shift_clk_i(sclk), .frame_sync_i(fs),
        .dout_i(dout), .tx_word_i(tx), .din_o(din), .got_word_o(got),
        .got_cnt_o(got_cnt));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // Words that arrive while the queue is full are lost, as in the port.
    // The port decides at the shift clock fall after the last input bit.
    always @(got_cnt) begin : model_push
        afesp_word_t w;
        w = cur;
        repeat (SCLK_HALF_CYCLES) @(posedge clk);
        if (q.size() < FIFO_DEPTH) q.push_back(w);
    end
    // Ready is set first, so the check sees what the next edge will pop.
    always @(negedge clk) begin
        rdy = (mode == 2) ? lf[0] : (mode == 1);
        if (!rst_i && rx_v === 1'b1 && rdy) begin
            if (q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                `CHK({rx_c, rx_w}, q[0])
                void'(q.pop_front());
            end
        end
    end
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic do_frame(input bit ctrl, input bit sw);
        int n;
        logic [15:0] want;
        n = got_cnt;
        lf = lfsr(lf);
        tx = ctrl ? {1'b0, sw, lf[13:0]} : lf;
        cur = {ctrl, tx};
        want = ctrl ? rb : adc;
        for (int i = 0; i < 4000 && got_cnt == n; i++) @(negedge clk);
        if (got_cnt == n) begin
            `CHK(1'b1, 1'b0)
            complete_run();
        end else begin
            `CHK(got, want)
            lf = lfsr(lf);
            if (ctrl) rb = lf;
            else adc = lf;
            cur.ctrl = 1'b0;
        end
    endtask : do_frame
    initial begin
        int t0;
        repeat (16) @(negedge clk);
        rst_i = 1'b0;
        mode = 2;
        repeat (4) do_frame(0, 0);
        hw_req = 1'b1;
        @(negedge clk);
        hw_req = 1'b0;
        do_frame(1, 1);
        do_frame(1, 0);
        do_frame(0, 0);
        $display("test control done");
        mode = 0;
        repeat (FIFO_DEPTH + 2) do_frame(0, 0);
        `CHK(adc_rdy, 1'b0)
        mode = 1;
        for (int i = 0; i < 2000 && q.size() > 0; i++) @(negedge clk);
        `CHK(q.size(), 0)
        `CHK(adc_rdy, 1'b1)
        $display("test fill done");
        for (int n = 2; n <= 6; n++) begin
            osr_n_i = n[2:0];
            repeat (2) do_frame(0, 0);
            t0 = t_fall;
            do_frame(0, 0);
            `CHK(t_fall - t0, OSR_BASE * n * 4)
        end
        $display("test ratio done");
        complete_run();
    end
endmodule : afe_serial_frame_port_test

// ==== dv/afesp_dsp_model.sv ====
// Signal processor model on the far side of the serial frame port.
// Assumes the port drives shift clock and frame sync; one word per frame.
`timescale 1ns/10ps
module afesp_dsp_model (
    input wire logic shift_clk_i, // Shift clock from the port.
    input wire logic frame_sync_i, // Frame sync from the port.
    input wire logic dout_i, // Port serial output.
    input wire logic [15:0] tx_word_i, // Word sent in the next frame.
    output logic din_o, // Port serial input.
    output logic [15:0] got_word_o, // Last whole word received.
    output int got_cnt_o // Count of words received.
);
    int bitn = 16;
    logic [15:0] sh;
    logic [15:0] rx;
    initial din_o = 1'b0;
    always @(posedge shift_clk_i) begin
        if (bitn < 16) begin
            rx = {rx[14:0], dout_i};
            bitn++;
            if (bitn == 16) begin
                got_word_o = rx;
                got_cnt_o++;
            end
        end
    end
    // Outside a frame the line toggles, so a stale bit can never pass.
    always @(negedge shift_clk_i) begin
        #1;
        if (!frame_sync_i && bitn == 16) begin
            bitn = 0;
            sh = tx_word_i;
            din_o = sh[15];
        end else if (bitn > 0 && bitn < 16) begin
            din_o = sh[15 - bitn];
        end else begin
            din_o = !din_o;
        end
    end
endmodule : afesp_dsp_model

// ==== dv/afesp_port_props.sv ====
// Checker of the serial frame port's pins and receive stream.
// Assumes it is bound to afesp_port; one clock, synchronous reset.
`timescale 1ns/10ps
module afesp_port_props (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset.
    input wire logic shift_clk_o, // Shift clock pin.
    input wire logic frame_sync_out_o, // Frame sync pin.
    input wire logic serial_out_o, // Serial output pin.
    input wire logic rx_valid_o, // Received word available.
    input wire logic rx_ready_i, // Consumer ready.
    input wire logic [15:0] rx_word_o, // Received word.
    input wire logic rx_ctrl_o // Control word flag.
);
    logic fs_q;
    logic [7:0] gap;
    // The gap saturates, so a long idle spell never wraps to a false hit.
    always_ff @(posedge clk_i) begin
        fs_q <= frame_sync_out_o;
        if (rst_i) begin
            gap <= 8'hff;
        end else if (fs_q && !frame_sync_out_o) begin
            gap <= 8'h01;
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_reset_idle: assert property (disable iff (1'b0)
        rst_i |=> frame_sync_out_o && !shift_clk_o) else $error("reset levels");
    chk_sclk_high: assert property (
        $rose(shift_clk_o) |-> shift_clk_o [*4] ##1 !shift_clk_o)
        else $error("shift clock high phase");
    chk_sclk_low: assert property (
        $fell(shift_clk_o) |-> !shift_clk_o [*4] ##1 shift_clk_o)
        else $error("shift clock low phase");
    chk_sync_at_fall: assert property (
        $fell(frame_sync_out_o) |-> !shift_clk_o) else $error("sync edge");
    chk_sync_pulse_len: assert property (
        $fell(frame_sync_out_o) |-> !frame_sync_out_o [*4]
        ##[1:5] frame_sync_out_o) else $error("sync pulse length");
    chk_interval_len: assert property (
        $fell(frame_sync_out_o) |-> gap >= 8'h80) else $error("short interval");
    chk_dout_steady: assert property (
        shift_clk_o && $past(shift_clk_o) |-> $stable(serial_out_o))
        else $error("output bit moved while clock high");
    chk_rx_hold: assert property (
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_o)
        && $stable(rx_ctrl_o)) else $error("received word not held");
    cover property ($fell(frame_sync_out_o));
    cover property (rx_valid_o && rx_ctrl_o);
    cover property (rx_valid_o && !rx_ready_i);
endmodule : afesp_port_props

bind afesp_port afesp_port_props u_props (.clk_i, .rst_i, .shift_clk_o,
    .frame_sync_out_o, .serial_out_o, .rx_valid_o, .rx_ready_i, .rx_word_o,
    .rx_ctrl_o);

// ==== src/afesp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module afesp_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset.
    input wire logic [WIDTH-1:0] in_data_i, // Write data.
    input wire logic in_valid_i, // Write request.
    output logic in_ready_o, // Not full.
    output logic [WIDTH-1:0] out_data_o, // Head word.
    output logic out_valid_o, // Not empty.
    input wire logic out_ready_i // Reader takes head.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= (AW+1)'(count + push - pop);
        end
    end
endmodule : afesp_fifo

// ==== src/afesp_pkg.sv ====
// Package of the serial frame port: timing counts, the stream word type,
// and the interval state type.
// Assumes a single 25 MHz system clock; no other file defines these names.
package afesp_pkg;
    localparam int WORD_BITS = 16;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_MIN_PERIOD_NS = 300;
    // Least shift-clock period rounds up to whole system cycles, then to an
    // even count so high and low halves are equal.
    localparam int SCLK_MIN_CYCLES =
        (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYCLES = (SCLK_MIN_CYCLES + 1) / 2;
    localparam int OSR_BASE = 32;
    localparam logic [2:0] OSR_N_RESET = 3'h5;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic ctrl;
        logic [WORD_BITS-1:0] word;
    } afesp_word_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_CTRL
    } afesp_state_t;
endpackage : afesp_pkg

// ==== src/afesp_port.sv ====
// Framing logic of the converter front end's synchronous serial port.
// Assumes the partner samples on the shift clock and that the pin inputs
// arrive asynchronously; the converter side is a same-clock stream.
`timescale 1ns/10ps
// Overview of operation
// - Device makes shift clock; every interval lasts exactly 16 shift clocks.
// - Data interval sends ADC word out while DAC word shifts in.
// - Control interval takes control word in, sends read-back data out.
// - Control interval only when hardware pin or control word requests it.
// - Only frame sync falling edge starts an interval.
// - Primary sync starts data interval; secondary sync starts control one.
// - One data interval per sample; primary syncs are one sample apart.
// - Sample rate is master clock divided by oversampling ratio.
module afesp_port
    import afesp_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input wire logic clk_i, // System clock, 25 MHz.
    input wire logic rst_i, // Synchronous reset.
    input wire logic mclk_i, // Master clock pin, oversampling rate.
    input wire logic [2:0] osr_n_i, // Ratio factor N, 2 to 6.
    input wire logic hw_ctrl_req_i, // Hardware control request pin.
    input wire logic [WORD_BITS-1:0] adc_word_i, // Converted sample.
    input wire logic adc_valid_i, // Sample strobe from ADC.
    input wire logic [WORD_BITS-1:0] readback_i, // Register read data.
    input wire logic serial_in_i, // Serial input pin.
    output logic serial_out_o, // Serial output pin.
    output logic shift_clk_o, // Shift clock pin.
    output logic frame_sync_out_o, // Frame sync pin, active falling.
    output logic [WORD_BITS-1:0] rx_word_o, // Received word.
    output logic rx_ctrl_o, // Received word was a control word.
    output logic rx_valid_o, // Received word available.
    input wire logic rx_ready_i, // Consumer takes received word.
    output logic adc_ready_o // Capture is free for a new sample and the receive FIFO is not full.
);
    localparam int SW = WORD_BITS;
    localparam logic [3:0] HALF = 4'(SCLK_HALF_CYCLES - 1);
    localparam logic [4:0] LAST_BIT = 5'(SW - 1);

    logic [2:0] mclk_sync;
    logic [1:0] req_sync;
    logic [1:0] din_sync;
    logic [10:0] mclk_count;
    logic [3:0] half_count;
    logic [4:0] bit_count;
    logic [SW-1:0] tx_shift;
    logic [SW-1:0] rx_shift;
    logic [SW-1:0] adc_hold;
    logic ctrl_pend;
    logic sclk;
    afesp_state_t state;
    afesp_state_t next_state;
    afesp_word_t fifo_in;
    afesp_word_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic rx_push;

    // Rising master clock edge, seen after the two-stage synchroniser.
    wire mclk_rise = mclk_sync[1] && !mclk_sync[2];
    wire [10:0] osr = 11'(OSR_BASE) * 11'(osr_n_i);
    wire sample_tick = mclk_rise && (mclk_count >= osr - 11'h001);
    wire half_end = (half_count == HALF);
    wire sclk_fall = half_end && sclk;
    wire sclk_rise = half_end && !sclk;
    wire last_bit = (bit_count == LAST_BIT);
    wire busy = (state != ST_IDLE);
    logic adc_valid_q;
    // Bit 14 of a received control word asks for another control interval.
    wire word_req = rx_push && (state == ST_CTRL) && rx_shift[SW-2];
    wire start_ctrl = !busy && ctrl_pend && sclk_fall;
    wire start_data = !busy && !ctrl_pend && adc_valid_q && sclk_fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mclk_sync <= 3'h0;
            req_sync <= 2'h0;
            din_sync <= 2'h0;
        end else begin
            mclk_sync <= {mclk_sync[1:0], mclk_i};
            req_sync <= {req_sync[0], hw_ctrl_req_i};
            din_sync <= {din_sync[0], serial_in_i};
        end
    end

    // Sampling period counter on master clock edges.
    always_ff @(posedge clk_i) begin
        if (rst_i || sample_tick) begin
            mclk_count <= 11'h000;
        end else if (mclk_rise) begin
            mclk_count <= 11'(mclk_count + 11'h001);
        end
    end

    // Free-running shift clock from the system clock divider.
    always_ff @(posedge clk_i) begin
        if (rst_i || half_end) begin
            half_count <= 4'h0;
        end else begin
            half_count <= 4'(half_count + 4'h1);
        end
        if (rst_i) begin
            sclk <= 1'b0;
        end else if (half_end) begin
            sclk <= !sclk;
        end
    end

    // One data interval per sample: a sample arms exactly one primary sync.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_valid_q <= 1'b0;
            adc_hold <= WORD_RESET;
        end else if (sample_tick && adc_valid_i) begin
            adc_valid_q <= 1'b1;
            adc_hold <= adc_word_i;
        end else if (start_data) begin
            adc_valid_q <= 1'b0;
        end
    end

    // Pending control request; a new request wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_pend <= 1'b0;
        end else if (req_sync[1] || word_req) begin
            ctrl_pend <= 1'b1;
        end else if (start_ctrl) begin
            ctrl_pend <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_ctrl) begin
                    next_state = ST_CTRL;
                end else if (start_data) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA, ST_CTRL: begin
                if (sclk_fall && last_bit) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    assign rx_push = busy && sclk_fall && last_bit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            bit_count <= 5'h00;
            tx_shift <= WORD_RESET;
            rx_shift <= WORD_RESET;
            frame_sync_out_o <= 1'b1;
            serial_out_o <= 1'b0;
            shift_clk_o <= 1'b0;
        end else begin
            state <= next_state;
            // Follow the divider's next level, so the pin falls on the same
            // edge as frame sync and the first output bit.
            shift_clk_o <= half_end ? !sclk : sclk;
            if (start_data || start_ctrl) begin
                // Falling frame sync opens the interval; rising carries
                // nothing and is merely the return to idle.
                frame_sync_out_o <= 1'b0;
                bit_count <= 5'h00;
                tx_shift <= start_ctrl ? readback_i : adc_hold;
                serial_out_o <= start_ctrl ? readback_i[SW-1]
                                           : adc_hold[SW-1];
            end else if (busy && sclk_fall) begin
                frame_sync_out_o <= 1'b1;
                bit_count <= 5'(bit_count + 5'h01);
                serial_out_o <= tx_shift[SW-2];
                tx_shift <= {tx_shift[SW-2:0], 1'b0};
            end
            if (busy && sclk_rise) begin
                rx_shift <= {rx_shift[SW-2:0], din_sync[1]};
            end
        end
    end

    // A received word is dropped only if the FIFO is full; the consumer
    // must keep up at the sample rate.
    assign fifo_in.ctrl = (state == ST_CTRL);
    assign fifo_in.word = rx_shift;

    afesp_fifo #(
        .WIDTH(SW + 1),
        .DEPTH(FIFO_DEPTH_P)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(fifo_in),
        .in_valid_i(rx_push),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(rx_ready_i && rx_valid_o)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_word_o <= WORD_RESET;
            rx_ctrl_o <= 1'b0;
            rx_valid_o <= 1'b0;
            adc_ready_o <= 1'b0;
        end else begin
            rx_word_o <= fifo_out.word;
            rx_ctrl_o <= fifo_out.ctrl;
            rx_valid_o <= fifo_out_valid && !(rx_ready_i && rx_valid_o);
            adc_ready_o <= !adc_valid_q && fifo_in_ready;
        end
    end
endmodule : afesp_port
